// ===== common/tcsc_pkg.sv
// constants and types for the timer channel start/stop control block
package tcsc_pkg;

  // ****************************************************************
  // register map (byte addresses on the register port)
  // ****************************************************************
  localparam logic [19:0] TCSC_START_ADDR  = 20'hf01b2;
  localparam logic [19:0] TCSC_START_LOW   = 20'hf01b2;
  localparam logic [19:0] TCSC_STOP_ADDR   = 20'hf01b4;
  localparam logic [19:0] TCSC_STOP_LOW    = 20'hf01b4;
  localparam logic [19:0] TCSC_ISEL_ADDR   = 20'hfff3e;
  localparam logic [19:0] TCSC_EN_ADDR     = 20'hf01b0;
  localparam logic [19:0] TCSC_MODE_BASE   = 20'hf0190;
  localparam logic [19:0] TCSC_RELOAD_BASE = 20'hf0180;
  localparam logic [19:0] TCSC_COUNT_BASE  = 20'hf0160;

  // ****************************************************************
  // fields and reset values
  // ****************************************************************
  localparam int          TCSC_IRQ_BIT    = 0;
  localparam int          TCSC_MODE_LO    = 1;
  localparam int          TCSC_MODE_HI    = 3;
  localparam int          TCSC_CCS_BIT    = 12;
  localparam logic [15:0] TCSC_TRIG_RST   = 16'h0000;
  localparam logic [7:0]  TCSC_ISEL_RST   = 8'h00;
  localparam logic [15:0] TCSC_MODE_RST   = 16'h0000;
  localparam logic [15:0] TCSC_RELOAD_RST = 16'h0000;
  localparam logic [15:0] TCSC_COUNT_RST  = 16'hffff;
  localparam logic [15:0] TCSC_ZERO       = 16'h0000;

  // ****************************************************************
  // modes and timing
  // ****************************************************************
  localparam logic [2:0] TCSC_M_INTERVAL = 3'h0;
  localparam logic [2:0] TCSC_M_CAPTURE  = 3'h2;
  localparam logic [2:0] TCSC_M_EVENT    = 3'h3;
  localparam logic [2:0] TCSC_M_ONECOUNT = 3'h4;
  localparam logic [2:0] TCSC_M_CAP_ONE  = 3'h6;
  localparam int         TCSC_SUB_DIV    = 4;
  localparam int         TCSC_CCLK_DIV   = 4;

  typedef enum logic [3:0] {
    TCSC_ST_IDLE  = 4'b0001,
    TCSC_ST_PEND  = 4'b0010,
    TCSC_ST_TWAIT = 4'b0100,
    TCSC_ST_RUN   = 4'b1000
  } tcsc_state_e;

endpackage

// ===== verilog/tcsc_top.sv
// timer channel start/stop control: triggers, enable status, start sequences
`timescale 1ns/100ps

// How it works
// - start bit write sets enable status; start bit clears once enable is one
// - stop bit write clears enable status; stop bit clears once enable is zero
// - start trigger register always reads zero
// - stop trigger register always reads zero
// - trigger registers take word writes; low byte alias takes byte writes
// - reset clears both trigger registers to zero
// - interval mode holds start until count clock, loads reload, then counts down
// - event mode start loads reload at once, count clocks then count down
// - event mode input edge never starts counting; disabled counter holds value
// - capture mode holds start until count clock, loads zero, then counts up
// - one-count start waits for trigger, then loads reload and counts down
// - capture one-count start waits for trigger, then loads zero, counts up
// - trigger-started modes always count on the operation clock
// - interval and capture first period may be one count clock late
// - start interrupt select raises channel interrupt at interval and capture count start
// - trigger modes start from the sampled input edge
// - input select bit picks timer pin or subsystem clock over four
// - input select is byte writable and resets to zero
// - mode field codes interval, capture, event, one-count, capture one-count
// - one-count restart trigger while running reloads, interrupts and restarts when start interrupt select is set
module tcsc_top
  import tcsc_pkg::*;
#(
  parameter int CCLK_DIV = TCSC_CCLK_DIV
)(
  input  wire logic        sys_clk,            // operation clock
  input  wire logic        rstn,               // async reset, active low
  input  wire logic [19:0] bus_addr,           // register address
  input  wire logic [15:0] bus_wdata,          // write data
  input  wire logic        bus_wr,             // write strobe
  input  wire logic        bus_rd,             // read strobe
  output logic      [15:0] bus_rdata,          // read data, cycle after strobe
  input  wire logic [7:0]  timer_input_pin,    // timer input pins
  input  wire logic        subsystem_clock,    // slow subsystem clock
  output logic      [7:0]  chan_enable_status, // per channel enable
  output logic      [7:0]  chan_irq            // per channel interrupt pulse
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // bit 3 marks a hit, bits 2:0 the channel
  function automatic logic [3:0] chan_hit(input logic [19:0] a,
                                          input logic [19:0] base);
    logic [19:0] d;
    d = a - base;
    chan_hit = {(d[19:4] == 16'h0000) && !d[0], d[3:1]};
  endfunction

  function automatic logic is_down(input logic [2:0] m);
    is_down = (m == TCSC_M_INTERVAL) || (m == TCSC_M_EVENT) ||
              (m == TCSC_M_ONECOUNT);
  endfunction

  function automatic logic is_trig_mode(input logic [2:0] m);
    is_trig_mode = (m == TCSC_M_ONECOUNT) || (m == TCSC_M_CAP_ONE);
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic [1:0] rst_pipe_reg;
  logic       rst_n_sync;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      rst_pipe_reg <= 2'h0;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_n_sync = rst_pipe_reg[1];

  // ****************************************************************
  // input synchronisers and subsystem clock divider
  // ****************************************************************
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  logic [1:0] sub_s_reg;
  logic       sub_prev_reg;
  logic       sub_cnt_reg;
  logic       sub_div_reg;
  logic [7:0] sel_prev_reg;
  logic [7:0] sel_in;
  logic [7:0] in_edge;
  logic [7:0] isel_reg;

  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
      sub_s_reg  <= 2'h0;
    end
    else
    begin
      pin_s1_reg <= timer_input_pin;
      pin_s2_reg <= pin_s1_reg;
      sub_s_reg  <= {sub_s_reg[0], subsystem_clock};
    end
  end

  // toggle every second rising edge: one period per four input periods
  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      sub_prev_reg <= 1'b0;
      sub_cnt_reg  <= 1'b0;
      sub_div_reg  <= 1'b0;
    end
    else
    begin
      sub_prev_reg <= sub_s_reg[1];
      if (sub_s_reg[1] && !sub_prev_reg)
      begin
        sub_cnt_reg <= !sub_cnt_reg;
        if (sub_cnt_reg)
          sub_div_reg <= !sub_div_reg;
      end
    end
  end

  assign sel_in  = (isel_reg & {8{sub_div_reg}}) | (~isel_reg & pin_s2_reg);
  assign in_edge = sel_in & ~sel_prev_reg;

  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      sel_prev_reg <= 8'h00;
    else
      sel_prev_reg <= sel_in;
  end

  // ****************************************************************
  // count clock prescaler
  // ****************************************************************
  logic [15:0] presc_cnt_reg;
  logic        presc_tick_reg;

  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      presc_cnt_reg  <= 16'h0000;
      presc_tick_reg <= 1'b0;
    end
    else if (presc_cnt_reg == 16'(CCLK_DIV - 1))
    begin
      presc_cnt_reg  <= 16'h0000;
      presc_tick_reg <= 1'b1;
    end
    else
    begin
      presc_cnt_reg  <= presc_cnt_reg + 16'h0001;
      presc_tick_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [15:0] mode_reg   [8];
  logic [15:0] reload_reg [8];
  logic [3:0]  wr_mode;
  logic [3:0]  wr_reload;
  logic        wr_start;
  logic        wr_stop;

  assign wr_mode   = chan_hit(bus_addr, TCSC_MODE_BASE);
  assign wr_reload = chan_hit(bus_addr, TCSC_RELOAD_BASE);
  assign wr_start  = bus_wr && (bus_addr == TCSC_START_ADDR || bus_addr == TCSC_START_LOW);
  assign wr_stop   = bus_wr && (bus_addr == TCSC_STOP_ADDR || bus_addr == TCSC_STOP_LOW);

  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      isel_reg <= TCSC_ISEL_RST;
      for (int n = 0; n < 8; n++)
      begin
        mode_reg[n]   <= TCSC_MODE_RST;
        reload_reg[n] <= TCSC_RELOAD_RST;
      end
    end
    else if (bus_wr)
    begin
      if (bus_addr == TCSC_ISEL_ADDR)
        isel_reg <= bus_wdata[7:0];
      else if (wr_mode[3])
        mode_reg[wr_mode[2:0]] <= bus_wdata & 16'h100f;
      else if (wr_reload[3])
        reload_reg[wr_reload[2:0]] <= bus_wdata;
    end
  end

  // ****************************************************************
  // trigger bits and enable status
  // ****************************************************************
  logic [7:0] start_bit_reg;
  logic [7:0] stop_bit_reg;
  logic [7:0] en_reg;
  logic [7:0] start_pulse_reg;

  // a new write wins over the self clear
  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      start_bit_reg   <= TCSC_TRIG_RST[7:0];
      stop_bit_reg    <= TCSC_TRIG_RST[7:0];
      en_reg          <= 8'h00;
      start_pulse_reg <= 8'h00;
    end
    else
    begin
      start_bit_reg   <= (start_bit_reg & ~en_reg) | (wr_start ? bus_wdata[7:0] : 8'h00);
      stop_bit_reg    <= (stop_bit_reg & en_reg) | (wr_stop ? bus_wdata[7:0] : 8'h00);
      start_pulse_reg <= wr_start ? bus_wdata[7:0] : 8'h00;
      if (wr_start)
        en_reg <= en_reg | bus_wdata[7:0];
      else if (wr_stop)
        en_reg <= en_reg & ~bus_wdata[7:0];
    end
  end

  // ****************************************************************
  // per channel start sequence and counter
  // ****************************************************************
  tcsc_state_e state_reg [8];
  logic [15:0] count_reg [8];
  logic [7:0]  irq_reg;
  logic [7:0]  cclk;
  logic [2:0]  cm [8];
  logic [7:0]  irq_sel;

  always_comb
  begin
    for (int n = 0; n < 8; n++)
    begin
      cm[n]      = mode_reg[n][TCSC_MODE_HI:TCSC_MODE_LO];
      irq_sel[n] = mode_reg[n][TCSC_IRQ_BIT];
      if (cm[n] == TCSC_M_EVENT)
        cclk[n] = in_edge[n];
      else if (is_trig_mode(cm[n]))
        cclk[n] = 1'b1;
      else if (mode_reg[n][TCSC_CCS_BIT])
        cclk[n] = presc_tick_reg;
      else
        cclk[n] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      irq_reg <= 8'h00;
      for (int n = 0; n < 8; n++)
      begin
        state_reg[n] <= TCSC_ST_IDLE;
        count_reg[n] <= TCSC_COUNT_RST;
      end
    end
    else
    begin
      for (int n = 0; n < 8; n++)
      begin
        irq_reg[n] <= 1'b0;
        if (!en_reg[n])
          state_reg[n] <= TCSC_ST_IDLE;
        else if (start_pulse_reg[n])
        begin
          if (cm[n] == TCSC_M_EVENT)
          begin
            count_reg[n] <= reload_reg[n];
            state_reg[n] <= TCSC_ST_RUN;
          end
          else if (is_trig_mode(cm[n]))
          begin
            if (state_reg[n] != TCSC_ST_RUN)
              state_reg[n] <= TCSC_ST_TWAIT;
            else if (cm[n] == TCSC_M_ONECOUNT && irq_sel[n])
            begin
              count_reg[n] <= reload_reg[n];
              irq_reg[n]   <= 1'b1;
            end
          end
          else
            state_reg[n] <= TCSC_ST_PEND;
        end
        else
        begin
          case (state_reg[n])
            TCSC_ST_PEND:
              if (cclk[n])
              begin
                count_reg[n] <= is_down(cm[n]) ? reload_reg[n] : TCSC_ZERO;
                state_reg[n] <= TCSC_ST_RUN;
                irq_reg[n]   <= irq_sel[n];
              end
            TCSC_ST_TWAIT:
              if (in_edge[n])
              begin
                count_reg[n] <= is_down(cm[n]) ? reload_reg[n] : TCSC_ZERO;
                state_reg[n] <= TCSC_ST_RUN;
              end
            TCSC_ST_RUN:
              if (cclk[n])
              begin
                if (!is_down(cm[n]))
                  count_reg[n] <= count_reg[n] + 16'h0001;
                else if (count_reg[n] != TCSC_ZERO)
                  count_reg[n] <= count_reg[n] - 16'h0001;
                else if (cm[n] == TCSC_M_ONECOUNT)
                begin
                  state_reg[n] <= TCSC_ST_TWAIT;
                  irq_reg[n]   <= 1'b1;
                end
                else
                begin
                  count_reg[n] <= reload_reg[n];
                  irq_reg[n]   <= 1'b1;
                end
              end
            default:
              state_reg[n] <= state_reg[n];
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [15:0] rdata_reg;
  logic [3:0]  rd_mode;
  logic [3:0]  rd_reload;
  logic [3:0]  rd_count;

  assign rd_mode   = chan_hit(bus_addr, TCSC_MODE_BASE);
  assign rd_reload = chan_hit(bus_addr, TCSC_RELOAD_BASE);
  assign rd_count  = chan_hit(bus_addr, TCSC_COUNT_BASE);

  always_ff @(posedge sys_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      rdata_reg <= 16'h0000;
    else if (!bus_rd)
      rdata_reg <= 16'h0000;
    else if (bus_addr == TCSC_START_ADDR)
      rdata_reg <= 16'h0000;
    else if (bus_addr == TCSC_STOP_ADDR)
      rdata_reg <= 16'h0000;
    else if (bus_addr == TCSC_ISEL_ADDR)
      rdata_reg <= {8'h00, isel_reg};
    else if (bus_addr == TCSC_EN_ADDR)
      rdata_reg <= {8'h00, en_reg};
    else if (rd_mode[3])
      rdata_reg <= mode_reg[rd_mode[2:0]];
    else if (rd_reload[3])
      rdata_reg <= reload_reg[rd_reload[2:0]];
    else if (rd_count[3])
      rdata_reg <= count_reg[rd_count[2:0]];
    else
      rdata_reg <= 16'h0000;
  end

  assign bus_rdata          = rdata_reg;
  assign chan_enable_status = en_reg;
  assign chan_irq           = irq_reg;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n_sync);

  sequence s_start_ch(int c, logic [2:0] m);
    en_reg[c] && start_pulse_reg[c] && cm[c] == m;
  endsequence

  a_start_sets_en:
    assert property (wr_start |=> (en_reg & $past(bus_wdata[7:0])) == $past(bus_wdata[7:0]))
    else $error("start write did not set enable");
  a_start_self_clr:
    assert property (!wr_start && (start_bit_reg & en_reg) != 8'h00 ##1 !wr_start |=> (start_bit_reg & en_reg) == 8'h00)
    else $error("start bit did not clear");
  a_stop_clears_en:
    assert property (wr_stop |=> (en_reg & $past(bus_wdata[7:0])) == 8'h00)
    else $error("stop write did not clear enable");
  a_stop_self_clr:
    assert property (!wr_stop |=> stop_bit_reg == 8'h00)
    else $error("stop bit did not clear");
  a_start_reads_zero:
    assert property (bus_rd && bus_addr == TCSC_START_ADDR |=> bus_rdata == 16'h0000)
    else $error("start register read not zero");
  a_stop_reads_zero:
    assert property (bus_rd && bus_addr == TCSC_STOP_ADDR |=> bus_rdata == 16'h0000)
    else $error("stop register read not zero");
  a_interval_hold:
    assert property (s_start_ch(1, TCSC_M_INTERVAL) |=> state_reg[1] == TCSC_ST_PEND && $stable(count_reg[1]))
    else $error("interval start not held");
  a_event_load:
    assert property (s_start_ch(0, TCSC_M_EVENT) |=> count_reg[0] == $past(reload_reg[0]))
    else $error("event start did not load reload");
  a_capture_zero:
    assert property (en_reg[2] && !start_pulse_reg[2] && state_reg[2] == TCSC_ST_PEND && cclk[2]
                     && cm[2] == TCSC_M_CAPTURE |=> count_reg[2] == 16'h0000 ##1 state_reg[2] == TCSC_ST_RUN)
    else $error("capture start did not load zero");
  a_onecount_wait:
    assert property (s_start_ch(3, TCSC_M_ONECOUNT) ##0 state_reg[3] != TCSC_ST_RUN
                     |=> state_reg[3] == TCSC_ST_TWAIT && $stable(count_reg[3]))
    else $error("one-count start did not wait");
  a_start_irq:
    assert property (en_reg[1] && !start_pulse_reg[1] && state_reg[1] == TCSC_ST_PEND && cclk[1]
                     && irq_sel[1] |=> chan_irq[1])
    else $error("no interrupt at count start");

endmodule

// ===== sim/tcsc_pin_model.sv
// far-side model: timer input pin pulses and a free-running subsystem clock
`timescale 1ns/100ps
module tcsc_pin_model
(
  input  wire logic       sys_clk,         // operation clock
  input  wire logic [7:0] edge_req,        // one-cycle request for a pin pulse
  output logic      [7:0] timer_input_pin, // timer input pins
  output logic            subsystem_clock  // slow clock, runs free
);
  logic [2:0] hold_reg;

  initial
  begin
    timer_input_pin = 8'h00;
    subsystem_clock = 1'b0;
    hold_reg        = 3'h0;
  end

  // oscillator runs free, phase unrelated to sys_clk
  always #73 subsystem_clock = ~subsystem_clock;

  // pulse held high four cycles so the two-flop sampler sees it
  always @(posedge sys_clk)
  begin
    if (edge_req != 8'h00)
    begin
      timer_input_pin <= edge_req;
      hold_reg        <= 3'h4;
    end
    else if (hold_reg != 3'h0)
    begin
      hold_reg <= hold_reg - 3'h1;
      if (hold_reg == 3'h1)
        timer_input_pin <= 8'h00;
    end
  end
endmodule

// ===== sim/tcsc_top_test.sv
// self-checking bench for the timer channel start/stop control
`timescale 1ns/100ps
module tcsc_top_test;
  import tcsc_pkg::*;

  logic        sys_clk   = 1'b0;
  logic        rstn      = 1'b0;
  logic [19:0] bus_addr  = 20'h00000;
  logic [15:0] bus_wdata = 16'h0000;
  logic        bus_wr    = 1'b0;
  logic        bus_rd    = 1'b0;
  logic [15:0] bus_rdata;
  logic [7:0]  edge_req  = 8'h00;
  logic [7:0]  timer_input_pin;
  logic        subsystem_clock;
  logic [7:0]  chan_enable_status;
  logic [7:0]  chan_irq;
  int          bad_count  = 0;
  int          n_compared = 0;

  always #5 sys_clk = ~sys_clk;

  tcsc_top #(.CCLK_DIV(2)) dut (
    .sys_clk            (sys_clk),
    .rstn               (rstn),
    .bus_addr           (bus_addr),
    .bus_wdata          (bus_wdata),
    .bus_wr             (bus_wr),
    .bus_rd             (bus_rd),
    .bus_rdata          (bus_rdata),
    .timer_input_pin    (timer_input_pin),
    .subsystem_clock    (subsystem_clock),
    .chan_enable_status (chan_enable_status),
    .chan_irq           (chan_irq)
  );

  tcsc_pin_model pins (
    .sys_clk         (sys_clk),
    .edge_req        (edge_req),
    .timer_input_pin (timer_input_pin),
    .subsystem_clock (subsystem_clock)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge sys_clk);
    bus_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge sys_clk);
    bus_rd   <= 1'b0;
    #1;
    d = bus_rdata;
  endtask

  task automatic rchk(input string what, input logic [19:0] a, input logic [15:0] exp);
    logic [15:0] v;
    rd(a, v);
    chk(what, v, exp);
  endtask

  // value must lie in lo..hi
  task automatic rng(input string what, input logic [19:0] a, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] v;
    rd(a, v);
    chk(what, 16'(v >= lo && v <= hi), 16'h0001);
  endtask

  task automatic echk(input logic [7:0] e);
    #1;
    chk("enable", {8'h00, chan_enable_status}, {8'h00, e});
  endtask

  task automatic pulse(input int ch);
    @(posedge sys_clk);
    edge_req <= 8'h01 << ch;
    @(posedge sys_clk);
    edge_req <= 8'h00;
  endtask

  task automatic wait_irq(input int ch);
    int i;
    for (i = 0; i < 200; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (chan_irq[ch] === 1'b1)
        return;
    end
    chk("irq wait", 16'h0000, 16'h0001);
    end_sim();
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    rchk("start", TCSC_START_ADDR, TCSC_TRIG_RST);
    rchk("stop", TCSC_STOP_ADDR, TCSC_TRIG_RST);
    rchk("isel", TCSC_ISEL_ADDR, 16'h0000);
    rchk("enable", TCSC_EN_ADDR, 16'h0000);
    rchk("unmapped", 20'h00010, 16'h0000);
  endtask

  task automatic t_event;
    wr(TCSC_RELOAD_BASE, 16'h0005);
    wr(TCSC_MODE_BASE, 16'h0006);
    pulse(0);
    cyc(8);
    rchk("cnt0 idle", TCSC_COUNT_BASE, TCSC_COUNT_RST);
    wr(TCSC_START_LOW, 16'h0001);
    echk(8'h01);
    rchk("cnt0 load", TCSC_COUNT_BASE, 16'h0005);
    rchk("start rd", TCSC_START_ADDR, 16'h0000);
    pulse(0);
    cyc(8);
    pulse(0);
    cyc(8);
    rchk("cnt0 down", TCSC_COUNT_BASE, 16'h0003);
  endtask

  task automatic t_interval;
    wr(TCSC_RELOAD_BASE + 20'h2, 16'h0040);
    wr(TCSC_MODE_BASE + 20'h2, 16'h0001);
    wr(TCSC_START_ADDR, 16'h0002);
    echk(8'h03);
    wait_irq(1);
    rng("cnt1", TCSC_COUNT_BASE + 20'h2, 16'h0038, 16'h003f);
  endtask

  task automatic t_capture;
    wr(TCSC_MODE_BASE + 20'h4, 16'h1004);
    wr(TCSC_START_ADDR, 16'h0004);
    echk(8'h07);
    cyc(20);
    rng("cnt2", TCSC_COUNT_BASE + 20'h4, 16'h0008, 16'h000e);
  endtask

  task automatic t_onecount;
    wr(TCSC_RELOAD_BASE + 20'h6, 16'h0080);
    wr(TCSC_MODE_BASE + 20'h6, 16'h0009);
    wr(TCSC_START_ADDR, 16'h0008);
    echk(8'h0f);
    cyc(10);
    rchk("cnt3 wait", TCSC_COUNT_BASE + 20'h6, TCSC_COUNT_RST);
    pulse(3);
    cyc(12);
    rng("cnt3 run", TCSC_COUNT_BASE + 20'h6, 16'h0070, 16'h007f);
    // software start while running: restart with reload and interrupt
    wr(TCSC_START_ADDR, 16'h0008);
    wait_irq(3);
    rng("cnt3 again", TCSC_COUNT_BASE + 20'h6, 16'h0078, 16'h0080);
  endtask

  task automatic t_cap_one;
    wr(TCSC_MODE_BASE + 20'h8, 16'h000c);
    wr(TCSC_START_ADDR, 16'h0010);
    echk(8'h1f);
    cyc(10);
    rchk("cnt4 wait", TCSC_COUNT_BASE + 20'h8, TCSC_COUNT_RST);
    pulse(4);
    cyc(8);
    rng("cnt4 run", TCSC_COUNT_BASE + 20'h8, 16'h0001, 16'h000c);
  endtask

  task automatic t_multi;
    wr(TCSC_START_ADDR, 16'h0060);
    echk(8'h7f);
    rchk("start rd2", TCSC_START_ADDR, 16'h0000);
  endtask

  task automatic t_stop_isel;
    logic [15:0] v;
    wr(TCSC_STOP_LOW, 16'h0001);
    echk(8'h7e);
    rchk("stop rd", TCSC_STOP_ADDR, 16'h0000);
    rd(TCSC_COUNT_BASE, v);
    pulse(0);
    cyc(8);
    rchk("cnt0 held", TCSC_COUNT_BASE, v);
    // channel 7 select left at zero for the serial receive route
    wr(TCSC_ISEL_ADDR, 16'h0001);
    rchk("isel rd", TCSC_ISEL_ADDR, 16'h0001);
    wr(TCSC_RELOAD_BASE, 16'h0020);
    wr(TCSC_START_ADDR, 16'h0001);
    echk(8'h7f);
    cyc(300);
    rng("cnt0 sub", TCSC_COUNT_BASE, 16'h0019, 16'h001d);
    wr(TCSC_STOP_ADDR, 16'h00ff);
    echk(8'h00);
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(3);
    t_reset();
    t_event();
    t_interval();
    t_capture();
    t_onecount();
    t_cap_one();
    t_multi();
    t_stop_isel();
    end_sim();
  end
endmodule
